// *** key_policy_pkg.sv ***
/*
  package for the key-use policy block: register offsets, field layouts,
  reset values, command codes and the packed carriers shared by the files.
  assumes a single 10 MHz clock domain and a plain register port.
*/
// Notes on behaviour
// - derive refused when used parent is limited and its bitmap is zero
// - derive target ignores its own limit enable and bitmap
// - successful derive sets target bitmap to FF; nothing else restores bits
// - derive allowed only when write policy bit 13 of slot is set
// - each use of a limited slot clears one bitmap bit until exhausted
// - slot 15 with limit enabled is governed by the last-key budget
// - key 15 use refused when every budget byte is zero
// - key 15 use clears first set bit from byte 68 bit 7 onward
// - budget bits are never restored; at most 128 uses of key 15
// - each key 15 use changes only one budget bit
// - plain read and write ignore limits and leave budget unchanged
// - response-compare copy does not check the limit enable
// - password copy works only with compare mode equal to 01
// - password copy needs target slot read-key pointer of zero
// - copy hash message: password slot first, then scratch key nonce
// - secondary mapping targets password slot with bit 0 set, else same slot
// - on match scratch key gets target key and flags 1,0,0,valid
// - selector at or above 8000 picks transport key, digest-generate only
// - below 8000 low four bits pick slot; full selector goes to hash
// - slots 0-7 with limit enabled clear highest set bitmap bit first
// - slots 8-14 have no bitmap limitation
package key_policy_pkg;

  // ----------------------------------------------------------------
  // sizes and constants
  // ----------------------------------------------------------------
  localparam int          NUM_LIMITED      = 8;
  localparam int          BUDGET_BYTES     = 16;
  localparam int          BUDGET_FIRST     = 68;
  localparam logic [3:0]  LAST_KEY_SLOT    = 4'hF;
  localparam logic [7:0]  BITMAP_FULL      = 8'hFF;
  localparam logic [7:0]  BITMAP_EMPTY     = 8'h00;
  localparam logic [7:0]  COPY_MODE        = 8'h01;
  localparam logic [15:0] TRANSPORT_BASE   = 16'h8000;
  localparam int          REFRESH_BIT      = 13;
  localparam int          PASSWORD_BYTES   = 32;

  // ----------------------------------------------------------------
  // register offsets (register port, word index)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_LIMIT_EN     = 8'h00; // slot limit enable, bit per slot
  localparam logic [7:0] REG_REFRESH_EN   = 8'h01; // write policy bit 13 per slot
  localparam logic [7:0] REG_READPTR_ZERO = 8'h02; // read key pointer zero per slot
  localparam logic [7:0] REG_STATUS       = 8'h03; // last result and scratch flags
  localparam logic [7:0] REG_BUDGET_LEFT  = 8'h04; // count of budget bits left
  localparam logic [7:0] REG_BITMAP_BASE  = 8'h10; // 8 words of use bitmaps
  localparam logic [7:0] REG_BUDGET_BASE  = 8'h20; // 16 words of budget bytes

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_LIMIT_EN   = 16'h0000;
  localparam logic [15:0] RST_REFRESH_EN = 16'h0000;
  localparam logic [15:0] RST_READPTR    = 16'h0000;
  localparam logic [7:0]  RST_BITMAP     = 8'hFF;
  localparam logic [7:0]  RST_BUDGET     = 8'hFF;

  // ----------------------------------------------------------------
  // commands and answers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ     = 3'h0,
    CMD_WRITE    = 3'h1,
    CMD_CRYPTO   = 3'h2,  // any key use: mac, hmac and the like
    CMD_DIGEST   = 3'h3,  // digest-generate
    CMD_REFRESH  = 3'h4,  // key refresh (derive)
    CMD_COMPARE  = 3'h5   // response compare
  } cmd_code_t;

  typedef enum logic [2:0] {
    RES_OK        = 3'h0,
    RES_EXHAUSTED = 3'h1,
    RES_NOT_ALLOW = 3'h2,
    RES_MISMATCH  = 3'h3,
    RES_BAD_SLOT  = 3'h4
  } result_t;

  // command request from the sequencer
  typedef struct packed {
    cmd_code_t  code;
    logic [15:0] slot_selector;
    logic [3:0]  parent_slot;     // refresh parent key slot
    logic        parent_used;     // parent used for auth or as source
    logic [7:0]  mode;            // compare mode byte
    logic        map_secondary;   // compare maps to password slot with bit 0 set
    logic        response_match;  // engine verdict for compare
  } cmd_req_t;

  // answer back to the sequencer
  typedef struct packed {
    logic        done;
    result_t     result;
    logic        use_transport;
    logic [3:0]  key_slot;
    logic [15:0] hash_selector;
    logic        copy_to_scratch;
    logic [3:0]  copy_slot;
    logic        hash_first_slot;  // message first half from password slot
  } cmd_ans_t;

  // scratch key flags
  typedef struct packed {
    logic source_is_fixed;
    logic produced_by_generator;
    logic verify_only_restriction;
    logic valid;
  } scratch_flags_t;

endpackage

// *** first_set_finder.sv ***
/*
  leaf: finds the first set bit of a vector scanning from msb of byte 0
  downward, byte by byte. bytes are packed byte 0 in the top lane.
  assumes a purely combinational context.
*/
`timescale 1ns/1ps
module first_set_finder #(
  parameter int WIDTH = 128
) (
  // vector in
  input  wire logic [WIDTH-1:0]         i_vec,
  // result
  output logic                          o_any,
  output logic [WIDTH-1:0]              o_clear_mask
);

  // ----------------------------------------------------------------
  // priority scan from the top bit
  // ----------------------------------------------------------------
  logic [WIDTH:0] seen;

  assign seen[WIDTH] = 1'b0;

  // one-hot mask of the highest set bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_scan
      assign seen[g]         = seen[g+1] | i_vec[g];
      assign o_clear_mask[g] = i_vec[g] & ~seen[g+1];
    end
  endgenerate

  assign o_any = seen[0];

endmodule // first_set_finder

// *** key_usage_policy.sv ***
/*
  key-use policy: decides whether a stored key may be used, consumes use
  bitmap and last-key budget bits, handles refresh of bitmaps and the
  password copy of the response-compare command.
  assumes the command sequencer gives one-cycle requests on i_sys_clk and
  the register port is a one-cycle strobe master with read data next cycle.
*/
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module key_usage_policy (
  // clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  // register port
  input  wire logic [7:0]                    i_reg_addr,
  input  wire logic [31:0]                   i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic [31:0]                        o_reg_rdata,
  // command request
  input  wire logic                          i_cmd_valid,
  input  wire key_policy_pkg::cmd_req_t      i_cmd,
  // command answer
  output key_policy_pkg::cmd_ans_t           o_ans,
  // scratch key
  output key_policy_pkg::scratch_flags_t     o_scratch_flags
);

  import key_policy_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]                 limit_en;
  logic [15:0]                 refresh_en;
  logic [15:0]                 readptr_zero;
  logic [7:0]                  use_count_bitmap [NUM_LIMITED];
  logic [8*BUDGET_BYTES-1:0]   last_key_budget;   // byte 68 in bits [127:120]
  scratch_flags_t              scratch;
  result_t                     last_result;
  cmd_ans_t                    ans;

  // ----------------------------------------------------------------
  // selector decoding
  // ----------------------------------------------------------------
  wire logic        is_transport = i_cmd.slot_selector >= TRANSPORT_BASE;
  wire logic [3:0]  sel_slot     = i_cmd.slot_selector[3:0];
  wire logic        sel_limited  = (sel_slot < 4'(NUM_LIMITED)) && limit_en[sel_slot];
  wire logic        sel_last_key = (sel_slot == LAST_KEY_SLOT) && limit_en[LAST_KEY_SLOT];
  wire logic [2:0]  sel_idx      = sel_slot[2:0];
  wire logic [7:0]  sel_bitmap   = use_count_bitmap[sel_idx];

  // parent of refresh
  wire logic [2:0]  par_idx      = i_cmd.parent_slot[2:0];
  wire logic        par_limited  = (i_cmd.parent_slot < 4'(NUM_LIMITED)) && limit_en[i_cmd.parent_slot];
  wire logic        par_empty    = par_limited && (use_count_bitmap[par_idx] == BITMAP_EMPTY);
  wire logic        par_lastkey  = (i_cmd.parent_slot == LAST_KEY_SLOT) && limit_en[LAST_KEY_SLOT];

  // compare copy target
  wire logic [3:0]  copy_slot    = i_cmd.map_secondary ? (sel_slot | 4'h1) : sel_slot;

  // ----------------------------------------------------------------
  // bit finders for bitmap and budget
  // ----------------------------------------------------------------
  logic                       bm_any;
  logic [7:0]                 bm_mask;
  logic                       bud_any;
  logic [8*BUDGET_BYTES-1:0]  bud_mask;

  first_set_finder #(.WIDTH(8)) u_bitmap_scan (
    .i_vec        (sel_bitmap),
    .o_any        (bm_any),
    .o_clear_mask (bm_mask)
  );

  first_set_finder #(.WIDTH(8*BUDGET_BYTES)) u_budget_scan (
    .i_vec        (last_key_budget),
    .o_any        (bud_any),
    .o_clear_mask (bud_mask)
  );

  // ----------------------------------------------------------------
  // decision logic
  // ----------------------------------------------------------------
  wire logic is_crypto   = (i_cmd.code == CMD_CRYPTO) || (i_cmd.code == CMD_DIGEST);
  wire logic is_refresh  = i_cmd.code == CMD_REFRESH;
  wire logic is_compare  = i_cmd.code == CMD_COMPARE;
  wire logic is_plain    = (i_cmd.code == CMD_READ) || (i_cmd.code == CMD_WRITE);

  // transport keys only for digest-generate
  wire logic transport_bad = is_transport && (i_cmd.code != CMD_DIGEST);
  // key use checks on the selected slot
  wire logic key_use       = is_crypto && !is_plain && !is_transport;
  wire logic bm_exhausted  = sel_limited && !bm_any;
  wire logic bud_exhausted = sel_last_key && !bud_any;
  // refresh checks: target limit ignored, parent honoured
  wire logic refresh_bad   = !refresh_en[sel_slot];
  wire logic parent_bad    = i_cmd.parent_used && (par_empty || (par_lastkey && !bud_any));
  // compare copy checks; limit enable not consulted
  wire logic copy_mode     = i_cmd.mode == COPY_MODE;
  wire logic copy_allowed  = copy_mode && readptr_zero[copy_slot];

  // result selection
  result_t next_result;
  always_comb begin
    next_result = RES_OK;
    if (transport_bad) begin
      next_result = RES_BAD_SLOT;
    end else if (key_use && (bm_exhausted || bud_exhausted)) begin
      next_result = RES_EXHAUSTED;
    end else if (is_refresh && refresh_bad) begin
      next_result = RES_NOT_ALLOW;
    end else if (is_refresh && parent_bad) begin
      next_result = RES_EXHAUSTED;
    end else if (is_compare && !i_cmd.response_match) begin
      next_result = RES_MISMATCH;
    end else begin
      next_result = RES_OK;
    end
  end

  wire logic cmd_ok       = i_cmd_valid && (next_result == RES_OK);
  wire logic consume_bm   = cmd_ok && key_use && sel_limited;
  wire logic consume_bud  = cmd_ok && key_use && sel_last_key;
  wire logic par_use_bm   = cmd_ok && is_refresh && i_cmd.parent_used && par_limited;
  wire logic refresh_tgt  = cmd_ok && is_refresh && (sel_slot < 4'(NUM_LIMITED));
  wire logic do_copy      = cmd_ok && is_compare && copy_allowed;

  // one-hot masks for the parent bitmap use
  logic [7:0] par_bitmap;
  logic [7:0] par_mask;
  assign par_bitmap = use_count_bitmap[par_idx];

  // highest set bit of the parent bitmap
  always_comb begin
    par_mask = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (par_bitmap[b] && (par_mask == 8'h00)) begin
        par_mask[b] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire logic        wr_limit   = i_reg_wr && (i_reg_addr == REG_LIMIT_EN);
  wire logic        wr_refresh = i_reg_wr && (i_reg_addr == REG_REFRESH_EN);
  wire logic        wr_readptr = i_reg_wr && (i_reg_addr == REG_READPTR_ZERO);
  wire logic        in_bitmap  = i_reg_addr[7:3] == REG_BITMAP_BASE[7:3];
  wire logic        in_budget  = i_reg_addr[7:4] == REG_BUDGET_BASE[7:4];
  wire logic [2:0]  reg_bm_idx = i_reg_addr[2:0];
  wire logic [3:0]  reg_bud_idx = i_reg_addr[3:0];

  // budget count of set bits
  logic [7:0] budget_left;
  always_comb begin
    budget_left = 8'h00;
    for (int b = 0; b < 8*BUDGET_BYTES; b++) begin
      budget_left = budget_left + 8'(last_key_budget[b]);
    end
  end

  // read mux
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_reg_addr == REG_LIMIT_EN) begin
      next_rdata = {16'h0000, limit_en};
    end else if (i_reg_addr == REG_REFRESH_EN) begin
      next_rdata = {16'h0000, refresh_en};
    end else if (i_reg_addr == REG_READPTR_ZERO) begin
      next_rdata = {16'h0000, readptr_zero};
    end else if (i_reg_addr == REG_STATUS) begin
      next_rdata = {25'h0000000, last_result, scratch};
    end else if (i_reg_addr == REG_BUDGET_LEFT) begin
      next_rdata = {24'h000000, budget_left};
    end else if (in_bitmap) begin
      next_rdata = {24'h000000, use_count_bitmap[reg_bm_idx]};
    end else if (in_budget) begin
      next_rdata = {24'h000000, last_key_budget[8*(BUDGET_BYTES-1-reg_bud_idx) +: 8]};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      limit_en     <= RST_LIMIT_EN;
      refresh_en   <= RST_REFRESH_EN;
      readptr_zero <= RST_READPTR;
      o_reg_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_limit)   limit_en     <= i_reg_wdata[15:0];
      if (wr_refresh) refresh_en   <= i_reg_wdata[15:0];
      if (wr_readptr) readptr_zero <= i_reg_wdata[15:0];
      o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // use bitmaps, one per limited slot
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < NUM_LIMITED; s++) begin : g_bitmap
      wire logic hit_sel = sel_idx == 3'(s);
      wire logic hit_par = par_idx == 3'(s);
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          use_count_bitmap[s] <= RST_BITMAP;
        end else if (refresh_tgt && hit_sel) begin
          use_count_bitmap[s] <= BITMAP_FULL;
        end else if (consume_bm && hit_sel) begin
          use_count_bitmap[s] <= use_count_bitmap[s] & ~bm_mask;
        end else if (par_use_bm && hit_par) begin
          use_count_bitmap[s] <= use_count_bitmap[s] & ~par_mask;
        end else if (i_reg_wr && in_bitmap && (reg_bm_idx == 3'(s))) begin
          use_count_bitmap[s] <= use_count_bitmap[s] & i_reg_wdata[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // last-key budget: bits only ever cleared
  // ----------------------------------------------------------------
  wire logic bud_par_use = cmd_ok && is_refresh && i_cmd.parent_used && par_lastkey;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      last_key_budget <= {BUDGET_BYTES{RST_BUDGET}};
    end else if (consume_bud || bud_par_use) begin
      last_key_budget <= last_key_budget & ~bud_mask;
    end else if (i_reg_wr && in_budget) begin
      // personalization can lower but never raise budget bits
      last_key_budget[8*(BUDGET_BYTES-1-reg_bud_idx) +: 8] <=
        last_key_budget[8*(BUDGET_BYTES-1-reg_bud_idx) +: 8] & i_reg_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // scratch key flags and answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scratch     <= '0;
      last_result <= RES_OK;
    end else begin
      if (do_copy) begin
        scratch <= '{source_is_fixed: 1'b1, produced_by_generator: 1'b0,
                     verify_only_restriction: 1'b0, valid: 1'b1};
      end
      if (i_cmd_valid) last_result <= next_result;
    end
  end

  // answer register, one cycle after the request
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ans <= '0;
    end else begin
      ans.done            <= i_cmd_valid;
      ans.result          <= i_cmd_valid ? next_result : RES_OK;
      ans.use_transport   <= i_cmd_valid && is_transport && !transport_bad;
      ans.key_slot        <= sel_slot;
      ans.hash_selector   <= i_cmd.slot_selector;
      ans.copy_to_scratch <= do_copy;
      ans.copy_slot       <= copy_slot;
      ans.hash_first_slot <= i_cmd_valid && is_compare && copy_mode;
    end
  end

  // answer and scratch flags out
  assign o_ans           = ans;
  assign o_scratch_flags = scratch;

endmodule // key_usage_policy

// *** key_usage_policy_checker.sv ***
/* checker for the key policy block: ties answers to the request taken
   one cycle before. assumes only the top module's ports are visible. */
`timescale 1ns/1ps
module key_usage_policy_checker
  import key_policy_pkg::*;
(
  // clock, reset and ports watched
  input wire logic                      i_sys_clk,
  input wire logic                      i_rst,
  input wire logic [7:0]                i_reg_addr,
  input wire logic [31:0]               i_reg_wdata,
  input wire logic                      i_reg_wr,
  input wire logic                      i_reg_rd,
  input wire logic [31:0]               o_reg_rdata,
  input wire logic                      i_cmd_valid,
  input wire key_policy_pkg::cmd_req_t  i_cmd,
  input wire key_policy_pkg::cmd_ans_t  o_ans,
  input wire key_policy_pkg::scratch_flags_t o_scratch_flags
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // request shapes
  sequence s_plain_use;
    i_cmd_valid && i_cmd.code == CMD_CRYPTO && i_cmd.slot_selector < TRANSPORT_BASE;
  endsequence
  sequence s_hidden(cmd_code_t c);
    i_cmd_valid && i_cmd.code == c && i_cmd.slot_selector >= TRANSPORT_BASE;
  endsequence
  sequence s_bad_mode;
    i_cmd_valid && i_cmd.code == CMD_COMPARE && i_cmd.mode != COPY_MODE;
  endsequence
  a_hidden_refused: assert property (s_hidden(CMD_CRYPTO) |=> o_ans.result == RES_BAD_SLOT)
    else $error("hidden key taken outside digest");
  a_hidden_digest: assert property (s_hidden(CMD_DIGEST) |=> o_ans.use_transport)
    else $error("digest missed hidden key");
  a_slot_low_bits: assert property (s_plain_use |=> o_ans.key_slot == $past(i_cmd.slot_selector[3:0])
    && o_ans.hash_selector == $past(i_cmd.slot_selector)) else $error("slot selection wrong");
  a_copy_mode_one: assert property (s_bad_mode |=> !o_ans.copy_to_scratch)
    else $error("copy with wrong mode");
  a_copy_slot_map: assert property (o_ans.copy_to_scratch |-> o_ans.copy_slot == ($past(i_cmd.map_secondary)
    ? ($past(i_cmd.slot_selector[3:0]) | 4'h1) : $past(i_cmd.slot_selector[3:0]))) else $error("copy slot wrong");
  a_copy_flags_set: assert property (o_ans.copy_to_scratch |=> o_scratch_flags == 4'h9)
    else $error("scratch flags wrong after copy");
  a_copy_first_half: assert property (o_ans.copy_to_scratch |-> o_ans.hash_first_slot)
    else $error("copy message order wrong");
  a_fail_no_copy: assert property (o_ans.done && o_ans.result != RES_OK |-> !o_ans.copy_to_scratch)
    else $error("copy on failed command");
endmodule // key_usage_policy_checker

bind key_usage_policy key_usage_policy_checker chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_ans(o_ans),
  .o_scratch_flags(o_scratch_flags));

// *** host_model.sv ***
/* host model: register port master and command issuer.
   assumes the bench calls its tasks only after reset is released. */
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic                     i_sys_clk,
  // register port
  output logic [7:0]                    o_reg_addr,
  output logic [31:0]                   o_reg_wdata,
  output logic                          o_reg_wr,
  output logic                          o_reg_rd,
  input  wire logic [31:0]              i_reg_rdata,
  // commands
  output logic                          o_cmd_valid,
  output key_policy_pkg::cmd_req_t      o_cmd,
  input  wire key_policy_pkg::cmd_ans_t i_ans
);
  import key_policy_pkg::*;
  // idle levels
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wdata = 32'h0;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b0;
    o_reg_wdata <= ~d;
  endtask
  // one-cycle read, data in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b0;
    #1;
    d = i_reg_rdata;
  endtask
  // personalising: only full or right-aligned budget bytes are sent
  task automatic set_budget(input logic [3:0] idx, input logic [7:0] b);
    if (b === (8'hFF >> (8 - $countones(b)))) begin
      wr(REG_BUDGET_BASE + {4'h0, idx}, {24'h0, b});
    end
  endtask
  // one-cycle command, answer in the following cycle
  task automatic issue(input cmd_req_t c, output cmd_ans_t a);
    @(posedge i_sys_clk);
    o_cmd <= c;
    o_cmd_valid <= 1'b1;
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b0;
    #1;
    a = i_ans;
  endtask
endmodule // host_model

// *** tb_key_usage_policy.sv ***
/* bench for the key policy block: scenario tasks through the host model.
   assumes a 10 MHz clock and active-high asynchronous reset. */
`timescale 1ns/1ps
module tb_key_usage_policy;
  import key_policy_pkg::*;
  logic           clk, rst, reg_wr, reg_rd, cmd_valid;
  logic [7:0]     reg_addr;
  logic [31:0]    reg_wdata, reg_rdata, rdv;
  cmd_req_t       cmd;
  cmd_ans_t       ans, a;
  scratch_flags_t flags;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  host_model host_u (.i_sys_clk(clk), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .i_ans(ans));
  key_usage_policy dut_u (.i_sys_clk(clk), .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .o_ans(ans), .o_scratch_flags(flags));
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    host_u.rd(ad, rdv);
    chk(rdv, exp);
  endtask
  // result 7 means any result
  task automatic go(cmd_code_t c, logic [15:0] s, logic [2:0] r, logic [7:0] md = 8'h00,
                    logic ms = 1'b0, logic mt = 1'b0, logic [3:0] ps = 4'h0, logic pu = 1'b0);
    host_u.issue('{c, s, ps, pu, md, ms, mt}, a);
    chk(a.done, 1'b1);
    if (r !== 3'h7) chk(a.result, r);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(REG_LIMIT_EN, 32'h0);
    rchk(REG_BITMAP_BASE + 8'h07, 32'hFF);
    rchk(REG_BUDGET_LEFT, 32'd128);
    rchk(8'h3F, 32'h0);
  endtask
  task automatic t_bitmap;
    host_u.wr(REG_LIMIT_EN, 32'h0000_0204);
    for (int k = 1; k <= 8; k++) begin
      go(CMD_CRYPTO, 16'h0002, RES_OK);
      rchk(REG_BITMAP_BASE + 8'h02, {24'h0, 8'hFF >> k});
    end
    go(CMD_CRYPTO, 16'h0002, RES_EXHAUSTED);
    rchk(REG_BITMAP_BASE + 8'h02, 32'h0);
    repeat (9) go(CMD_CRYPTO, 16'h0009, RES_OK);
  endtask
  task automatic t_refresh;
    go(CMD_REFRESH, 16'h0002, RES_NOT_ALLOW);
    rchk(REG_BITMAP_BASE + 8'h02, 32'h0);
    host_u.wr(REG_REFRESH_EN, 32'h0000_0004);
    host_u.wr(REG_LIMIT_EN, 32'h0000_020C);
    host_u.wr(REG_BITMAP_BASE + 8'h03, 32'h0);
    go(CMD_REFRESH, 16'h0002, RES_EXHAUSTED, 8'h00, 1'b0, 1'b0, 4'h3, 1'b1);
    rchk(REG_BITMAP_BASE + 8'h02, 32'h0);
    go(CMD_REFRESH, 16'h0002, RES_OK, 8'h00, 1'b0, 1'b0, 4'h3, 1'b0);
    rchk(REG_BITMAP_BASE + 8'h02, 32'hFF);
  endtask
  task automatic t_budget;
    host_u.wr(REG_LIMIT_EN, 32'h0000_8000);
    for (int i = 0; i < BUDGET_BYTES; i++) host_u.set_budget(i[3:0], (i == 1) ? 8'h03 : 8'h00);
    rchk(REG_BUDGET_LEFT, 32'd2);
    go(CMD_READ, 16'h000F, RES_OK);
    go(CMD_WRITE, 16'h000F, RES_OK);
    rchk(REG_BUDGET_BASE + 8'h01, 32'h03);
    go(CMD_CRYPTO, 16'h000F, RES_OK);
    rchk(REG_BUDGET_BASE + 8'h01, 32'h01);
    rchk(REG_BUDGET_BASE, 32'h00);
    go(CMD_DIGEST, 16'h000F, RES_OK);
    go(CMD_CRYPTO, 16'h000F, RES_EXHAUSTED);
    host_u.wr(REG_BUDGET_BASE + 8'h01, 32'hFF);
    rchk(REG_BUDGET_LEFT, 32'h0);
  endtask
  task automatic t_select;
    go(CMD_DIGEST, 16'h8001, RES_OK);
    chk(a.use_transport, 1'b1);
    go(CMD_CRYPTO, 16'h8001, RES_BAD_SLOT);
    go(CMD_CRYPTO, 16'h1234, RES_OK);
    chk({a.key_slot, a.hash_selector}, {4'h4, 16'h1234});
  endtask
  task automatic t_compare;
    host_u.wr(REG_READPTR_ZERO, 32'h0000_0020);
    host_u.wr(REG_LIMIT_EN, 32'h0000_8020);
    host_u.wr(REG_BITMAP_BASE + 8'h05, 32'h0);
    go(CMD_COMPARE, 16'h0004, RES_OK, 8'h00, 1'b1, 1'b1);
    chk(a.copy_to_scratch, 1'b0);
    go(CMD_COMPARE, 16'h0004, RES_MISMATCH, COPY_MODE, 1'b1, 1'b0);
    go(CMD_COMPARE, 16'h0004, 3'h7, COPY_MODE, 1'b0, 1'b1);
    chk({a.copy_to_scratch, flags}, 5'h00);
    go(CMD_COMPARE, 16'h0004, RES_OK, COPY_MODE, 1'b1, 1'b1);
    chk({a.copy_to_scratch, a.copy_slot, a.hash_first_slot}, {1'b1, 4'h5, 1'b1});
    @(posedge clk);
    #1;
    chk(flags, 4'h9);
    rchk(REG_STATUS, 32'h0000_0009);
  endtask
  // verdict
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bitmap();
    t_refresh();
    t_budget();
    t_select();
    t_compare();
    conclude();
  end
endmodule // tb_key_usage_policy
